/* File: verilog/ccd_pkg.sv */
// Purpose: Shared constants and types for the clock divider and switch command block
// Assumes: 8-bit registers reached over a plain strobe port
// Notes: Register offsets are indices on the local register port
package ccd_pkg;
    localparam logic [1:0] ADDR_DIVIDER = 2'h0;
    localparam logic [1:0] ADDR_COMMAND = 2'h1;
    localparam logic [1:0] ADDR_SELECT = 2'h2;

    localparam int UNLOCK_BIT = 7;
    localparam int READY_BIT = 4;
    localparam int OUT_SEL_BIT = 6;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    localparam logic [3:0] DIV_RESET_FUSED = 4'h3;
    localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
    localparam logic [3:0] DIV_MAX_CODE = 4'h8;
    localparam logic [7:0] UNLOCK_ONLY = 8'h80;

    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_DISABLE = 4'b0001,
        CMD_ENABLE = 4'b0010,
        CMD_AVAIL = 4'b0011,
        CMD_SWITCH = 4'b0100,
        CMD_RECOVER = 4'b0101,
        CMD_WDOG_ARL = 4'b0110,
        CMD_CLKOUT = 4'b0111
    } ccd_cmd_e;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [3:0] source;
        logic [1:0] startup;
        logic clockOut;
    } ccd_cmd_s;
endpackage : ccd_pkg

/* File: verilog/ccd_clock_control.sv */
// Purpose: Divider control and clock switch command registers
// Assumes: Fuse levels static pins, sampled after reset release; source ready/current from switch
// Notes: The divided clock is produced by a counter-based enable-gated divider
`timescale 1ns/1ps
module ccd_clock_control (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic divideByEightFuse,
    input wire logic clockOutputFuse,
    input wire logic [1:0] startupFuse,
    input wire logic [3:0] sourceSelectFuse,
    input wire logic sourceStable,
    input wire logic [3:0] currentSource,
    output ccd_pkg::ccd_cmd_s switchCmd,
    output logic [3:0] divisionSelect,
    output logic divClockEnable,
    output logic watchdogAutoReload
);
    logic [2:0] fuseSync_q;
    logic fuseLoad_q;
    logic [2:0] stableSync_q;
    logic stable_q;
    logic divUnlock_q;
    logic [2:0] divCount_q;
    logic cmdUnlock_q;
    logic [2:0] cmdCount_q;
    logic [3:0] division_q;
    logic [3:0] cmdCode_q;
    logic ready_q;
    logic clockOut_q;
    logic [1:0] startup_q;
    logic [3:0] source_q;
    logic [7:0] divCnt_q;
    logic [3:0] activeDiv_q;
    logic autoReload_q;
    logic divOutEn_q;
    ccd_pkg::ccd_cmd_s cmd_q;
    logic [7:0] rdata_q;
    logic wrDiv;
    logic wrCmd;
    logic wrSel;
    logic unlockWrite;
    logic cmdFire;
    logic [7:0] divMask;

    assign wrDiv = regWrite && regAddr == ccd_pkg::ADDR_DIVIDER;
    assign wrCmd = regWrite && regAddr == ccd_pkg::ADDR_COMMAND;
    assign wrSel = regWrite && regAddr == ccd_pkg::ADDR_SELECT;
    assign unlockWrite = regWdata == ccd_pkg::UNLOCK_ONLY;
    assign cmdFire = wrCmd && cmdUnlock_q && !regWdata[ccd_pkg::UNLOCK_BIT];

    // Fuse strobe after reset release; flag marks the one load cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fuseSync_q <= 3'h0;
            fuseLoad_q <= 1'b1;
        end else begin
            fuseSync_q <= {fuseSync_q[1:0], 1'b1};
            fuseLoad_q <= 1'b0;
        end
    end

    // Stable indication from the switch passes three sync flops, then a flop that follows only when the last two agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stableSync_q <= 3'h0;
            stable_q <= 1'b0;
        end else begin
            stableSync_q <= {stableSync_q[1:0], sourceStable};
            if (stableSync_q[1] == stableSync_q[2]) begin
                stable_q <= stableSync_q[2];
            end
        end
    end

    // Divider unlock window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divUnlock_q <= 1'b0;
            divCount_q <= 3'h0;
        end else if (divUnlock_q) begin
            if (wrDiv && !regWdata[ccd_pkg::UNLOCK_BIT]) begin
                divUnlock_q <= 1'b0;
            end else if (divCount_q == ccd_pkg::UNLOCK_CYCLES - 3'h1) begin
                divUnlock_q <= 1'b0;
            end
            divCount_q <= divCount_q + 3'h1;
        end else if (wrDiv && unlockWrite) begin
            divUnlock_q <= 1'b1;
            divCount_q <= 3'h0;
        end
    end

    // Division field
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            division_q <= ccd_pkg::DIV_RESET_PLAIN;
        end else if (fuseLoad_q) begin
            division_q <= divideByEightFuse ? ccd_pkg::DIV_RESET_FUSED
                                            : ccd_pkg::DIV_RESET_PLAIN;
        end else if (wrDiv && divUnlock_q && !regWdata[ccd_pkg::UNLOCK_BIT]) begin
            division_q <= regWdata[3:0];
        end
    end

    // Command unlock window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmdUnlock_q <= 1'b0;
            cmdCount_q <= 3'h0;
        end else if (cmdUnlock_q) begin
            if (cmdFire) begin
                cmdUnlock_q <= 1'b0;
            end else if (cmdCount_q == ccd_pkg::UNLOCK_CYCLES - 3'h1) begin
                cmdUnlock_q <= 1'b0;
            end
            cmdCount_q <= cmdCount_q + 3'h1;
        end else if (wrCmd && unlockWrite) begin
            cmdUnlock_q <= 1'b1;
            cmdCount_q <= 3'h0;
        end
    end

    // Command field, issue strobe and sticky watchdog mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmdCode_q <= 4'h0;
            cmd_q <= '0;
            autoReload_q <= 1'b0;
        end else begin
            cmd_q.valid <= 1'b0;
            if (cmdFire) begin
                cmdCode_q <= regWdata[3:0];
                cmd_q.valid <= !regWdata[3];
                cmd_q.code <= regWdata[3:0];
                cmd_q.source <= source_q;
                cmd_q.startup <= startup_q;
                cmd_q.clockOut <= regWdata[3:0] == ccd_pkg::CMD_CLKOUT && clockOut_q;
                if (regWdata[3:0] == ccd_pkg::CMD_WDOG_ARL) begin
                    autoReload_q <= 1'b1;
                end
            end
        end
    end

    // Ready flag: clear on request, set by confirmed stable clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b0;
        end else if (cmdFire && (regWdata[3:0] == ccd_pkg::CMD_AVAIL
                                 || regWdata[3:0] == ccd_pkg::CMD_ENABLE)) begin
            ready_q <= 1'b0;
        end else if (stable_q) begin
            ready_q <= 1'b1;
        end
    end

    // Source selection register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clockOut_q <= 1'b0;
            startup_q <= 2'h0;
            source_q <= 4'h0;
        end else if (fuseLoad_q) begin
            clockOut_q <= !clockOutputFuse;
            startup_q <= startupFuse;
            source_q <= sourceSelectFuse;
        end else if (cmdFire && regWdata[3:0] == ccd_pkg::CMD_RECOVER) begin
            source_q <= currentSource;
        end else if (wrSel) begin
            clockOut_q <= regWdata[ccd_pkg::OUT_SEL_BIT];
            startup_q <= regWdata[5:4];
            source_q <= regWdata[3:0];
        end
    end

    // Divided clock enable; new factor taken only at a period boundary
    always_comb begin
        divMask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(activeDiv_q)) begin
                divMask[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 8'h00;
            activeDiv_q <= ccd_pkg::DIV_RESET_PLAIN;
            divOutEn_q <= 1'b0;
        end else begin
            divOutEn_q <= (divCnt_q & divMask) == divMask;
            if ((divCnt_q & divMask) == divMask) begin
                divCnt_q <= 8'h00;
                if (division_q <= ccd_pkg::DIV_MAX_CODE) begin
                    activeDiv_q <= division_q;
                end
            end else begin
                divCnt_q <= divCnt_q + 8'h01;
            end
        end
    end

    // Read data one cycle after strobe; reserved bits zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                ccd_pkg::ADDR_DIVIDER: rdata_q <= {divUnlock_q, 3'h0, division_q};
                ccd_pkg::ADDR_COMMAND: rdata_q <= {cmdUnlock_q, 2'h0, ready_q, cmdCode_q};
                ccd_pkg::ADDR_SELECT: rdata_q <= {1'b0, clockOut_q, startup_q, source_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divisionSelect <= ccd_pkg::DIV_RESET_PLAIN;
        end else begin
            divisionSelect <= activeDiv_q;
        end
    end

    assign regRdata = rdata_q;
    assign switchCmd = cmd_q;
    assign divClockEnable = divOutEn_q;
    assign watchdogAutoReload = autoReload_q;
endmodule : ccd_clock_control

/* File: verif/ccd_props.sv */
// Purpose: Port assertions for the clock control block
// Assumes: Bound to ccd_clock_control, one clock domain
// Notes: Read data is checked for zero outside the slot after a read strobe, and for command and select register reserved bits inside it
`timescale 1ns/1ps
module ccd_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire ccd_pkg::ccd_cmd_s switchCmd,
    input wire logic [3:0] divisionSelect,
    input wire logic divClockEnable,
    input wire logic watchdogAutoReload
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_cmd_one_pulse: assert property (switchCmd.valid |=> !switchCmd.valid)
        else $error("long command pulse");
    a_cmd_from_write: assert property (switchCmd.valid |-> $past(regWrite) &&
        $past(regAddr) == 2'h1 && switchCmd.code == $past(regWdata[3:0]))
        else $error("stray command");
    a_cmd_code_legal: assert property (switchCmd.valid |-> !switchCmd.code[3])
        else $error("reserved code issued");
    a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data outside slot");
    a_reserved_zero: assert property ($past(regRead) |->
        !(regRdata[7] && $past(regAddr) == 2'h2) && !((|regRdata[6:5]) && $past(regAddr) == 2'h1))
        else $error("reserved bit set");
    a_div_code_legal: assert property (divisionSelect <= 4'h8)
        else $error("reserved division applied");
    a_wdog_sticky: assert property (watchdogAutoReload |=> watchdogAutoReload)
        else $error("auto reload dropped");
    a_div_no_fast: assert property (divClockEnable && divisionSelect != 4'h0
        ##1 $stable(divisionSelect) |-> !divClockEnable) else $error("pulses too close");
    cover property (switchCmd.valid && switchCmd.code == 4'h5);
    cover property ($rose(watchdogAutoReload));
    cover property (divisionSelect == 4'h8 && divClockEnable);
endmodule : ccd_props

/* File: verif/tb_clock_divider_and_switch_cmd.sv */
// Purpose: Self-checking bench for the clock control block
// Assumes: Fuses stay fixed through each reset
// Notes: Fuses other than divideByEightFuse, and select values, are random from a fixed seed
`timescale 1ns/1ps
module tb_clock_divider_and_switch_cmd;
    logic clk = 1'h0, resetn = 1'h0, regWrite = 1'h0, regRead = 1'h0, sourceStable = 1'h0;
    logic divideByEightFuse = 1'h0, clockOutputFuse = 1'h0, divClockEnable, watchdogAutoReload;
    logic [1:0] regAddr = 2'h0, startupFuse = 2'h0;
    logic [3:0] sourceSelectFuse = 4'h0, currentSource = 4'h0, divisionSelect;
    logic [7:0] regWdata = 8'h00, regRdata, sel;
    ccd_pkg::ccd_cmd_s switchCmd;
    int error_cnt = 0, n_compared = 0, k;
    always #25 clk = ~clk;
    ccd_clock_control ccd_clock_control_i (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .divideByEightFuse(divideByEightFuse), .clockOutputFuse(clockOutputFuse),
        .startupFuse(startupFuse), .sourceSelectFuse(sourceSelectFuse),
        .sourceStable(sourceStable), .currentSource(currentSource), .switchCmd(switchCmd),
        .divisionSelect(divisionSelect), .divClockEnable(divClockEnable),
        .watchdogAutoReload(watchdogAutoReload));
    task automatic close_out(input int late);
        error_cnt += late;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        {regAddr, regWdata, regWrite} <= {a, d, 1'h1};
        @(posedge clk);
        regWrite <= 1'h0;
    endtask : wr
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        {regAddr, regRead} <= {a, 1'h1};
        @(posedge clk);
        regRead <= 1'h0;
        #1 check(regRdata, exp);
    endtask : rdc
    task automatic seq(input logic [1:0] a, input logic [7:0] d);
        // Nothing else may touch the bus between the two writes
        wr(a, 8'h80);
        wr(a, d);
    endtask : seq
    // Period between the second and third pulse once the new code is in force
    task automatic period(input logic [3:0] c);
        int n = 0, t = 0, j;
        for (j = 0; j < 1200 && n < 3; j++) begin
            @(posedge clk);
            #1;
            if (divisionSelect === c && divClockEnable === 1'h1) begin
                n++;
                t = (n == 2) ? j : t;
            end
        end
        if (n < 3) close_out(1);
        check(12'(j - 1 - t), 12'h1 << c);
    endtask : period
    initial begin
        void'($urandom(32'h0000_c189));
        {clockOutputFuse, startupFuse, sourceSelectFuse} <= 7'($urandom);
        for (k = 0; k < 2; k++) begin
            divideByEightFuse <= k[0];
            resetn <= 1'h0;
            repeat (8) @(posedge clk);
            resetn <= 1'h1;
            repeat (2) @(posedge clk);
            rdc(2'h0, k[0] ? 8'h03 : 8'h00);
            rdc(2'h2, {1'h0, ~clockOutputFuse, startupFuse, sourceSelectFuse});
            rdc(2'h1, 8'h00);
            rdc(2'h3, 8'h00);
        end
        $display("reset values done");
        wr(2'h0, 8'h05);
        wr(2'h0, 8'h81);
        wr(2'h0, 8'h05);
        rdc(2'h0, 8'h03);
        wr(2'h0, 8'h80);
        rdc(2'h0, 8'h83);
        repeat (3) @(posedge clk);
        wr(2'h0, 8'h05);
        rdc(2'h0, 8'h03);
        for (k = 0; k < 9; k++) begin
            seq(2'h0, 8'(k));
            rdc(2'h0, 8'(k));
            period(4'(k));
        end
        seq(2'h0, 8'h09);
        repeat (300) @(posedge clk);
        check(divisionSelect, 4'h8);
        $display("divider done");
        sel = 8'($urandom) & 8'h7f;
        currentSource <= ~sel[3:0];
        wr(2'h2, sel);
        rdc(2'h2, sel);
        for (k = 0; k < 16; k++) begin
            seq(2'h1, 8'(k));
            #1;
            if (k > 7) check(switchCmd.valid, 1'h0);
            else if (k != 0 && k != 5)
                check(switchCmd, {1'h1, 4'(k), sel[3:0], sel[5:4], sel[6] && k == 7});
            rdc(2'h1, 8'(k));
            if (k == 5) begin
                sel[3:0] = currentSource;
                rdc(2'h2, sel);
            end
        end
        check(watchdogAutoReload, 1'h1);
        $display("commands done");
        sourceStable <= 1'h1;
        repeat (8) @(posedge clk);
        rdc(2'h1, 8'h1f);
        for (k = 2; k < 4; k++) begin
            sourceStable <= 1'h0;
            repeat (4) @(posedge clk);
            seq(2'h1, 8'(k));
            rdc(2'h1, 8'(k));
            sourceStable <= 1'h1;
            repeat (8) @(posedge clk);
            rdc(2'h1, 8'h10 | 8'(k));
        end
        $display("ready flag done");
        wr(2'h1, 8'h80);
        wr(2'h1, 8'h80);
        @(posedge clk);
        wr(2'h1, 8'h04);
        #1 check(switchCmd.valid, 1'h0);
        wr(2'h1, 8'h81);
        wr(2'h1, 8'h04);
        rdc(2'h1, 8'h13);
        $display("unlock checks done");
        close_out(0);
    end
endmodule : tb_clock_divider_and_switch_cmd
bind ccd_clock_control ccd_props ccd_props_i (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .switchCmd(switchCmd), .divisionSelect(divisionSelect), .divClockEnable(divClockEnable),
    .watchdogAutoReload(watchdogAutoReload));
